// *** design/sub_alu.sv ***
`timescale 1ns/1ps
module sub_alu (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic carry,
  output logic digit_carry,
  output logic zero
);
  wire [8:0] full_sum;
  wire [4:0] low_sum;
  // Two's complement: a + ~b + 1
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff = full_sum[7:0];
  assign carry = full_sum[8];
  assign digit_carry = low_sum[4];
  assign zero = (full_sum[7:0] == 8'h00);
endmodule

// *** design/subexec_defines.svh ***
`ifndef SUBEXEC_DEFINES_SVH
`define SUBEXEC_DEFINES_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_INSTR 12'h000
`define ADDR_WREG 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_FILE_BASE 12'h100

// ----------------------------------------
// Instruction fields, status bit positions, W reset value and file depth
// ----------------------------------------
`define OPC_IMM_TOP 5'h1e
`define OPC_FILE_TOP 6'h02
`define STATUS_C_BIT 0
`define STATUS_DIGIT_CARRY_BIT 1
`define STATUS_Z_BIT 2
`define STATUS_BUSY_BIT 3
`define WREG_RESET 8'h00
`define FILE_DEPTH 128

`endif

// *** design/subexec_pkg.sv ***
package subexec_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_IMM, OP_FILE} op_t;
endpackage

// *** design/subtract_instruction_exec.sv ***
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "subexec_defines.svh"

// Overview of operation
// - Immediate form computes literal minus working register
// - Decode immediate opcode 11 110x plus literal
// - Immediate result replaces working register
// - Only carry, digit carry, zero updated
// - Positive result sets carry, clears zero
// - Zero result sets carry and zero
// - Negative result clears carry and zero, wraps
// - Four phases: decode, read, process, write
module subtract_instruction_exec #(
  parameter int FILE_DEPTH = `FILE_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] wreg_out,
  output logic [2:0] flags_out,
  output logic busy
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire setup_wr;
  wire acc;
  wire sel_instr;
  wire sel_wreg;
  wire sel_status;
  wire sel_file;
  wire [6:0] file_idx;
  wire [11:0] file_off;
  wire mapped;
  assign acc = psel && penable;
  assign setup_wr = psel && !penable && pwrite;
  assign sel_instr = (paddr == `ADDR_INSTR);
  assign sel_wreg = (paddr == `ADDR_WREG);
  assign sel_status = (paddr == `ADDR_STATUS);
  assign file_off = paddr - `ADDR_FILE_BASE;
  assign sel_file = (paddr >= `ADDR_FILE_BASE) && (file_off[11:9] == 3'h0) && (file_off[1:0] == 2'h0);
  assign file_idx = file_off[8:2];
  assign mapped = sel_instr || sel_wreg || sel_status || sel_file;

  logic [7:0] wreg_reg;
  logic [7:0] file_reg [FILE_DEPTH];
  logic c_reg;
  logic digit_carry_reg;
  logic z_reg;
  logic [13:0] instr_reg;
  subexec_pkg::phase_t phase_reg;
  subexec_pkg::op_t op_reg;
  logic [7:0] opa_reg;
  logic [7:0] opb_reg;
  logic [7:0] res_reg;
  logic res_c_reg;
  logic res_digit_carry_reg;
  logic res_z_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic busy_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire is_imm;
  wire is_file;
  wire dest_file;
  wire [6:0] f_addr;
  assign is_imm = (instr_reg[13:9] == `OPC_IMM_TOP);
  assign is_file = (instr_reg[13:8] == `OPC_FILE_TOP);
  assign dest_file = instr_reg[7];
  assign f_addr = instr_reg[6:0];

  wire [7:0] alu_diff;
  wire alu_c;
  wire alu_digit_carry;
  wire alu_z;
  sub_alu u_alu (
    .minuend(opa_reg),
    .subtrahend(opb_reg),
    .diff(alu_diff),
    .carry(alu_c),
    .digit_carry(alu_digit_carry),
    .zero(alu_z)
  );

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  wire start;
  assign start = setup_wr && sel_instr && (phase_reg == subexec_pkg::PH_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= subexec_pkg::PH_IDLE;
    end else begin
      case (phase_reg)
        subexec_pkg::PH_IDLE: if (start) phase_reg <= subexec_pkg::PH_DECODE;
        subexec_pkg::PH_DECODE: phase_reg <= subexec_pkg::PH_READ;
        subexec_pkg::PH_READ: phase_reg <= subexec_pkg::PH_PROCESS;
        subexec_pkg::PH_PROCESS: phase_reg <= subexec_pkg::PH_WRITE;
        subexec_pkg::PH_WRITE: phase_reg <= subexec_pkg::PH_IDLE;
        default: phase_reg <= subexec_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 14'h0000;
    end else if (start) begin
      instr_reg <= pwdata[13:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= subexec_pkg::OP_NONE;
    end else if (phase_reg == subexec_pkg::PH_DECODE) begin
      op_reg <= is_imm ? subexec_pkg::OP_IMM : (is_file ? subexec_pkg::OP_FILE : subexec_pkg::OP_NONE);
    end
  end

  // literal (immediate) or file register (file form) as minuend, W as subtrahend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_reg <= 8'h00;
      opb_reg <= 8'h00;
    end else if (phase_reg == subexec_pkg::PH_READ) begin
      opa_reg <= (op_reg == subexec_pkg::OP_IMM) ? instr_reg[7:0] : file_reg[f_addr];
      opb_reg <= wreg_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= 8'h00;
      res_c_reg <= 1'b0;
      res_digit_carry_reg <= 1'b0;
      res_z_reg <= 1'b0;
    end else if (phase_reg == subexec_pkg::PH_PROCESS) begin
      res_reg <= alu_diff;
      res_c_reg <= alu_c;
      res_digit_carry_reg <= alu_digit_carry;
      res_z_reg <= alu_z;
    end
  end

  // ----------------------------------------
  // Write back
  // ----------------------------------------
  wire wb;
  wire wb_w;
  wire wb_f;
  wire bus_wr;
  assign wb = (phase_reg == subexec_pkg::PH_WRITE) && (op_reg != subexec_pkg::OP_NONE);
  assign wb_w = wb && ((op_reg == subexec_pkg::OP_IMM) || !dest_file);
  assign wb_f = wb && (op_reg == subexec_pkg::OP_FILE) && dest_file;
  assign bus_wr = acc && pwrite && pready_reg && (phase_reg == subexec_pkg::PH_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_reg <= `WREG_RESET;
    end else if (wb_w) begin
      wreg_reg <= res_reg;
    end else if (bus_wr && sel_wreg) begin
      wreg_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_reg <= 1'b0;
      digit_carry_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (wb) begin
      c_reg <= res_c_reg;
      digit_carry_reg <= res_digit_carry_reg;
      z_reg <= res_z_reg;
    end else if (bus_wr && sel_status) begin
      c_reg <= pwdata[`STATUS_C_BIT];
      digit_carry_reg <= pwdata[`STATUS_DIGIT_CARRY_BIT];
      z_reg <= pwdata[`STATUS_Z_BIT];
    end
  end

  // ----------------------------------------
  // File registers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          file_reg[gi] <= 8'h00;
        end else if (wb_f && (f_addr == 7'(gi))) begin
          file_reg[gi] <= res_reg;
        end else if (bus_wr && sel_file && (file_idx == 7'(gi))) begin
          file_reg[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  wire busy_now;
  wire blocked;
  wire [31:0] rd_mux;
  assign busy_now = (phase_reg != subexec_pkg::PH_IDLE);
  // Register writes other than to the instruction register wait while an instruction runs
  assign blocked = pwrite && busy_now && !sel_instr;
  assign rd_mux = sel_instr ? {18'h00000, instr_reg} :
                  sel_wreg ? {24'h000000, wreg_reg} :
                  sel_status ? {28'h0000000, busy_now, z_reg, digit_carry_reg, c_reg} :
                  sel_file ? {24'h000000, file_reg[file_idx]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end else if (phase_reg == subexec_pkg::PH_WRITE) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel && !pready_reg && !blocked;
      pslverr_reg <= psel && !pready_reg && !blocked && !mapped;
      prdata_reg <= (psel && !pwrite && !pready_reg) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign wreg_out = wreg_reg;
  assign flags_out = {z_reg, digit_carry_reg, c_reg};
  assign busy = busy_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_phases;
    phase_reg == subexec_pkg::PH_DECODE ##1 phase_reg == subexec_pkg::PH_READ
      ##1 phase_reg == subexec_pkg::PH_PROCESS ##1 phase_reg == subexec_pkg::PH_WRITE;
  endsequence

  a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> s_phases) else $error("phase order broken");
  a_imm_result: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_reg == subexec_pkg::PH_PROCESS && op_reg == subexec_pkg::OP_IMM)
      |=> res_reg == 8'(instr_reg[7:0] - opb_reg)) else $error("immediate difference wrong");
  a_imm_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_reg == subexec_pkg::PH_DECODE && instr_reg[13:9] == 5'h1e) |=> op_reg == subexec_pkg::OP_IMM)
    else $error("immediate not decoded");
  a_w_written: assert property (@(posedge pclk) disable iff (!presetn)
    (wb && op_reg == subexec_pkg::OP_IMM) |=> wreg_reg == $past(res_reg)) else $error("W not written");
  a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_now && !wb) |=> $stable(flags_out)) else $error("flags changed early");
  a_positive: assert property (@(posedge pclk) disable iff (!presetn)
    (wb && opa_reg > opb_reg) |=> c_reg && !z_reg) else $error("positive flags wrong");
  a_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (wb && opa_reg == opb_reg) |=> c_reg && z_reg) else $error("zero flags wrong");
  a_negative: assert property (@(posedge pclk) disable iff (!presetn)
    (wb && opa_reg < opb_reg) |=> !c_reg && !z_reg) else $error("negative flags wrong");
  a_file_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (wb && op_reg == subexec_pkg::OP_FILE && dest_file) |=> $stable(wreg_reg)) else $error("W touched");

endmodule

// *** verification/subtract_instruction_exec_bench.sv ***
`timescale 1ns/1ps
module subtract_instruction_exec_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] wreg_out;
  logic [2:0] flags_out;
  logic busy;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int samples_checked = 0;

  always #25 pclk = ~pclk;

  subtract_instruction_exec dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wreg_out(wreg_out), .flags_out(flags_out), .busy(busy)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task stop_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("Error pready expected 1 seen 0");
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0);
      n++;
    end while (rd[3] !== 1'b0 && n < 50);
    if (rd[3] !== 1'b0) begin
      error_cnt++;
      $display("Error busy expected 0 seen 1");
      stop_test;
    end
  endtask

  function automatic logic [2:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return {d == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task run_imm(input logic [7:0] w, input logic [7:0] k, input logic xbit);
    apb(1'b1, 12'h004, {24'h0, w});
    apb(1'b1, 12'h000, {18'h0, 5'h1e, xbit, k});
    wait_idle;
    check("wreg", {24'h0, k - w}, {24'h0, wreg_out});
    check("flags", {29'h0, exp_flags(k, w)}, {29'h0, flags_out});
    apb(1'b0, 12'h004, 32'h0);
    check("wreg read", {24'h0, k - w}, rd);
    apb(1'b0, 12'h008, 32'h0);
    check("status read", {29'h0, exp_flags(k, w)}, rd);
  endtask

  task run_phases;
    apb(1'b1, 12'h004, 32'h00000005);
    apb(1'b1, 12'h000, {18'h0, 14'h3c09});
    #1 check("busy", 32'h1, {31'h0, busy});
    repeat (2) @(posedge pclk);
    #1 check("wreg early", 32'h5, {24'h0, wreg_out});
    @(posedge pclk);
    #1 check("wreg late", 32'h4, {24'h0, wreg_out});
    wait_idle;
  endtask

  task run_file(input logic [6:0] f, input logic [7:0] fv, input logic [7:0] w, input logic d);
    apb(1'b1, 12'h100 + {3'h0, f, 2'b00}, {24'h0, fv});
    apb(1'b1, 12'h004, {24'h0, w});
    apb(1'b1, 12'h000, {18'h0, 6'h02, d, f});
    wait_idle;
    check("file flags", {29'h0, exp_flags(fv, w)}, {29'h0, flags_out});
    check("file wreg", {24'h0, d ? w : fv - w}, {24'h0, wreg_out});
    apb(1'b0, 12'h100 + {3'h0, f, 2'b00}, 32'h0);
    check("file reg", {24'h0, d ? fv - w : fv}, rd);
  endtask

  task run_refuse;
    apb(1'b1, 12'h004, 32'h00000001);
    apb(1'b1, 12'h000, {18'h0, 14'h3c10});
    apb(1'b1, 12'h000, {18'h0, 14'h3c80});
    wait_idle;
    check("ignored", 32'h0f, {24'h0, wreg_out});
    apb(1'b0, 12'h0fc, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    check("unmapped", 32'h0, rd);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1 check("reset", 32'h0, {20'h0, wreg_out, flags_out, busy});
    run_imm(8'h01, 8'h02, 1'b0);
    run_imm(8'h02, 8'h02, 1'b0);
    run_imm(8'h03, 8'h02, 1'b1);
    run_imm(8'h01, 8'h10, 1'b0);
    run_imm(8'h00, 8'hff, 1'b1);
    run_phases;
    run_file(7'd5, 8'h03, 8'h02, 1'b1);
    run_file(7'd127, 8'h01, 8'h02, 1'b0);
    run_file(7'd0, 8'h22, 8'h22, 1'b0);
    run_refuse;
    stop_test;
  end
endmodule
